/* File: verilog/timer_pkg.sv */
// Purpose: Shared constants for the capture/compare timer block
// Assumes: AXI4-Lite register map, 32-bit data, byte addresses
// Notes:   Mode, clock-select and sample-select codes are register values
`default_nettype none
package timer_pkg;
  // ==================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_MODE = 6'h00;
  localparam logic [5:0] OFF_CLKSEL = 6'h04;
  localparam logic [5:0] OFF_OUTCTL = 6'h08;
  localparam logic [5:0] OFF_EDGE = 6'h0C;
  localparam logic [5:0] OFF_SAMPLE = 6'h10;
  localparam logic [5:0] OFF_CMP1 = 6'h14;
  localparam logic [5:0] OFF_CMP2 = 6'h18;
  localparam logic [5:0] OFF_COUNT = 6'h1C;
  localparam logic [5:0] OFF_FLAGS = 6'h20;
  // ==================================================
  // Field positions and reset values
  localparam int CLK_SEL_LO = 4;
  localparam int OUT_EN_BIT = 0;
  localparam int ACT_LVL_BIT = 1;
  localparam int EV_EDGE_LO = 2;
  localparam int SEC_EDGE_LO = 4;
  localparam int FLAG1_BIT = 0;
  localparam int FLAG2_BIT = 1;
  localparam logic [15:0] RESET_CMP = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // ==================================================
  // Mode codes
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_CAP1 = 3'h1;
  localparam logic [2:0] MODE_DUAL = 3'h2;
  localparam logic [2:0] MODE_CAP2REG = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_PULSE = 3'h5;
  // Count clock codes
  localparam logic [2:0] CSEL_EXT = 3'h0;
  localparam logic [2:0] CSEL_DIV1 = 3'h1;
  localparam logic [2:0] CSEL_DIV2 = 3'h2;
  localparam logic [2:0] CSEL_DIV4 = 3'h3;
  localparam logic [2:0] CSEL_DIV8 = 3'h4;
  // Sample clock codes: every clock, /64, /16, /32
  localparam logic [1:0] SMP_DIV1 = 2'h0;
  localparam logic [1:0] SMP_DIV64 = 2'h1;
  localparam logic [1:0] SMP_DIV16 = 2'h2;
  localparam logic [1:0] SMP_DIV32 = 2'h3;
  // Edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // PWM shape
  localparam int PWM_BASIC_BITS = 8;
  localparam int PWM_SUB_BITS = 14;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==================================================
  // Edge decode, shared by both input pins
  function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      EDGE_FALL: edgeHit = fall;
      EDGE_RISE: edgeHit = rise;
      EDGE_BOTH: edgeHit = rise | fall;
      default: edgeHit = 1'b0; // Prohibited code: no edge
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: verilog/edge_filter.sv */
// Purpose: Two-sample noise filter and edge detector for one input pin
// Assumes: Pin is synchronous to clock; stable level resets low
// Notes:   Edge pulses come one clock after the confirming sample
`default_nettype none
module edge_filter (
  input wire logic clock,      // System clock
  input wire logic resetn,     // Async reset, active low
  input wire logic pin,        // Raw pin level
  input wire logic sampleTick, // Sample strobe
  output logic rise,           // Filtered rising edge pulse
  output logic fall            // Filtered falling edge pulse
);
  typedef struct packed {
    logic last;
    logic stable;
    logic rise;
    logic fall;
  } filt_t;
  filt_t s;
  filt_t next_s;

  // ==================================================
  // A level counts only when two successive samples agree
  always_comb begin
    next_s = s;
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    if (sampleTick) begin
      next_s.last = pin;
      if (s.last == pin && pin != s.stable) begin
        next_s.stable = pin;
        next_s.rise = pin;
        next_s.fall = !pin;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

  // ==================================================
  a_filter_confirm: assert property (@(posedge clock) disable iff (!resetn)
    sampleTick && pin && s.last && !s.stable |=> rise)
    else $error("confirmed high level gave no rise");
  a_filter_noise: assert property (@(posedge clock) disable iff (!resetn)
    sampleTick && (pin != s.last) |=> !rise && !fall)
    else $error("single sample produced an edge");
endmodule
`default_nettype wire

/* File: verilog/pwm_dither.sv */
// Purpose: Active decision for the dithered PWM waveform
// Assumes: pos walks the sub-cycle one step per count tick
// Notes:   Purely combinational; the caller registers the pin
`default_nettype none
module pwm_dither
  import timer_pkg::*;
#(
  parameter int SUB_BITS = PWM_SUB_BITS,
  parameter int BASIC_BITS = PWM_BASIC_BITS
) (
  input wire logic [SUB_BITS-1:0] duty, // Duty in count units
  input wire logic [SUB_BITS-1:0] pos,  // Position in sub-cycle
  output logic active                   // Output active now
);
  localparam int IDX_BITS = SUB_BITS - BASIC_BITS;
  logic [IDX_BITS-1:0] revIdx;
  logic extra;
  logic [BASIC_BITS:0] thresh;

  initial begin
    if (IDX_BITS < 1) $error("SUB_BITS must exceed BASIC_BITS");
  end

  // ==================================================
  // Bit reversal spreads the extra counts evenly over the basic cycles
  for (genvar i = 0; i < IDX_BITS; i++) begin : g_rev
    assign revIdx[i] = pos[SUB_BITS-1-i];
  end

  // Each basic cycle is high for duty's upper bits, plus one in some cycles
  assign extra = revIdx < duty[IDX_BITS-1:0];
  assign thresh = {1'b0, duty[SUB_BITS-1:IDX_BITS]} + {{BASIC_BITS{1'b0}}, extra};
  assign active = {1'b0, pos[BASIC_BITS-1:0]} < thresh;
endmodule
`default_nettype wire

/* File: verilog/timer_capture.sv */
// Purpose: 16-bit timer with PWM, pulse and capture modes on AXI4-Lite
// Assumes: Pins synchronous to clock; one outstanding read and write
// Notes:   Hardware captures win over a bus write in the same cycle
//
// Local design decisions: the address map and register access over AXI4-Lite.
`default_nettype none
// How it works
// - PWM mode drives duty-set pulses on output
// - Duty comes from compare one upper 14 bits
// - Output control bit 1 picks active level
// - Basic cycle 256, sub-cycle 16384 count clocks
// - Clock select bits 6..4 pick count clock
// - Output control bit 0 enables the pin
// - Average active time equals compare upper 14 bits over 16384
// - Pulse mode: width compare two, period one
// - Event edge captures counter, sets first flag
// - Event edge rising, falling or both, bits 3..2
// - Event pin needs two agreeing samples
// - Second pin captures into compare one, flag two
// - Opposite event edge captures into compare one
// - Two-register mode uses single edge only
// - Both-edge setting blocks the opposite capture
// - Edge codes: 00 fall, 01 rise, 11 both
module timer_capture
  import timer_pkg::*;
#(
  parameter int PRE_W = 8
) (
  input wire logic clock,                 // System clock, 10 MHz
  input wire logic resetn,                // Async reset, active low
  input wire logic [ADDR_W-1:0] awaddr,   // Write address
  input wire logic awvalid,               // Write address valid
  output logic awready,                   // Write address ready
  input wire logic [31:0] wdata,          // Write data
  input wire logic [3:0] wstrb,           // Write byte strobes
  input wire logic wvalid,                // Write data valid
  output logic wready,                    // Write data ready
  output logic [1:0] bresp,               // Write response
  output logic bvalid,                    // Write response valid
  input wire logic bready,                // Write response ready
  input wire logic [ADDR_W-1:0] araddr,   // Read address
  input wire logic arvalid,               // Read address valid
  output logic arready,                   // Read address ready
  output logic [31:0] rdata,              // Read data
  output logic [1:0] rresp,               // Read response
  output logic rvalid,                    // Read data valid
  input wire logic rready,                // Read data ready
  input wire logic eventInputPin,         // Event and capture input
  input wire logic secondCapturePin,      // Second capture input
  output logic timerOutputPin,            // Timer output
  output logic firstExtIrq,               // Event capture pulse
  output logic secondExtIrq               // Second pin capture pulse
);
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] clkSel;
    logic [1:0] outCtl;
    logic [5:2] edgeMode;
    logic [1:0] sampleSel;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] count;
    logic flag1;
    logic flag2;
    logic irq1;
    logic irq2;
    logic [PRE_W-1:0] pre;
    logic outPin;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic awHave;
    logic wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;
  state_t s;
  state_t next_s;

  logic evRise, evFall, secRise, secFall;
  logic sampleTick, countTick, evHit, secHit, invHit;
  logic capMode, doWrite, wrCmp1, pwmActive, active;
  logic [31:0] mask, wv;

  initial begin
    if (PRE_W < 6) $error("PRE_W must be at least 6");
  end

  // ==================================================
  // Address decode, used by both read and write paths
  function automatic logic addrOk(input logic [ADDR_W-1:0] a);
    case ({a[ADDR_W-1:2], 2'b00})
      OFF_MODE, OFF_CLKSEL, OFF_OUTCTL, OFF_EDGE, OFF_SAMPLE,
      OFF_CMP1, OFF_CMP2, OFF_COUNT, OFF_FLAGS: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  endfunction

  // Register read view; unused bits read zero
  function automatic logic [31:0] readMux(input state_t st, input logic [ADDR_W-1:0] a);
    readMux = 32'h0000_0000;
    case ({a[ADDR_W-1:2], 2'b00})
      OFF_MODE: readMux[2:0] = st.mode;
      OFF_CLKSEL: readMux[CLK_SEL_LO+:3] = st.clkSel;
      OFF_OUTCTL: readMux[1:0] = st.outCtl;
      OFF_EDGE: readMux[5:2] = st.edgeMode;
      OFF_SAMPLE: readMux[1:0] = st.sampleSel;
      OFF_CMP1: readMux[15:0] = st.cmp1;
      OFF_CMP2: readMux[15:0] = st.cmp2;
      OFF_COUNT: readMux[15:0] = st.count;
      OFF_FLAGS: readMux[1:0] = {st.flag2, st.flag1};
      default: readMux = 32'h0000_0000;
    endcase
  endfunction

  // ==================================================
  // Input filters: event pin at sample rate, second pin every clock
  edge_filter u_event_filter (
    .clock(clock),
    .resetn(resetn),
    .pin(eventInputPin),
    .sampleTick(sampleTick),
    .rise(evRise),
    .fall(evFall)
  );

  edge_filter u_second_filter (
    .clock(clock),
    .resetn(resetn),
    .pin(secondCapturePin),
    .sampleTick(1'b1),
    .rise(secRise),
    .fall(secFall)
  );

  // Duty is the upper 14 bits; the low two bits are left to software
  pwm_dither u_pwm (
    .duty(s.cmp1[15:2]),
    .pos(s.count[PWM_SUB_BITS-1:0]),
    .active(pwmActive)
  );

  // ==================================================
  // Sample and divided count strobes from one free prescaler; the external count strobe is the event edge
  always_comb begin
    case (s.sampleSel)
      SMP_DIV64: sampleTick = &s.pre[5:0];
      SMP_DIV16: sampleTick = &s.pre[3:0];
      SMP_DIV32: sampleTick = &s.pre[4:0];
      default: sampleTick = 1'b1;
    endcase
    case (s.clkSel)
      CSEL_EXT: countTick = evHit;
      CSEL_DIV1: countTick = 1'b1;
      CSEL_DIV2: countTick = s.pre[0];
      CSEL_DIV4: countTick = &s.pre[1:0];
      CSEL_DIV8: countTick = &s.pre[2:0];
      default: countTick = 1'b0; // Prohibited selections stop the count
    endcase
  end

  // Edge decoding per pin; opposite edge only for a single-edge setting
  assign evHit = edgeHit(s.edgeMode[EV_EDGE_LO+:2], evRise, evFall);
  assign secHit = edgeHit(s.edgeMode[SEC_EDGE_LO+:2], secRise, secFall);
  assign invHit = (s.edgeMode[EV_EDGE_LO+:2] == EDGE_RISE) ? evFall :
                  (s.edgeMode[EV_EDGE_LO+:2] == EDGE_FALL) ? evRise : 1'b0;
  assign capMode = s.mode == MODE_CAP1 || s.mode == MODE_DUAL || s.mode == MODE_CAP2REG;
  assign doWrite = s.awHave && s.wHave && !s.bValid;
  assign wrCmp1 = doWrite && {s.awAddr[ADDR_W-1:2], 2'b00} == OFF_CMP1;

  // Active decision for the two waveform modes
  always_comb begin
    case (s.mode)
      MODE_PWM: active = pwmActive;
      MODE_PULSE: active = s.count <= s.cmp2;
      default: active = 1'b0;
    endcase
  end

  // ==================================================
  // Next state: bus slave first, then hardware updates override it
  always_comb begin
    next_s = s;
    next_s.pre = s.pre + 1'b1;
    next_s.irq1 = 1'b0;
    next_s.irq2 = 1'b0;
    for (int i = 0; i < 4; i++) begin
      mask[8*i+:8] = {8{s.wStrb[i]}};
    end
    wv = (s.wData & mask) | (readMux(s, s.awAddr) & ~mask);
    // Address and data may arrive in either order
    if (awvalid && s.awRdy) begin
      next_s.awHave = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wRdy) begin
      next_s.wHave = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (doWrite) begin
      next_s.awHave = 1'b0;
      next_s.wHave = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = addrOk(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
      case ({s.awAddr[ADDR_W-1:2], 2'b00})
        OFF_MODE: next_s.mode = wv[2:0];
        OFF_CLKSEL: next_s.clkSel = wv[CLK_SEL_LO+:3];
        OFF_OUTCTL: next_s.outCtl = wv[1:0];
        OFF_EDGE: next_s.edgeMode = wv[5:2];
        OFF_SAMPLE: next_s.sampleSel = wv[1:0];
        OFF_CMP1: next_s.cmp1 = wv[15:0];
        OFF_CMP2: next_s.cmp2 = wv[15:0];
        OFF_FLAGS: begin
          // Write one to clear
          if (s.wData[FLAG1_BIT] && s.wStrb[0]) next_s.flag1 = 1'b0;
          if (s.wData[FLAG2_BIT] && s.wStrb[0]) next_s.flag2 = 1'b0;
        end
        default: next_s.bResp = addrOk(s.awAddr) ? RESP_OKAY : RESP_SLVERR; // Counter is read-only, writes ignored
      endcase
    end
    if (s.bValid && bready) next_s.bValid = 1'b0;
    if (arvalid && s.arRdy) begin
      next_s.rValid = 1'b1;
      next_s.rData = readMux(s, araddr);
      next_s.rResp = addrOk(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rValid && rready) next_s.rValid = 1'b0;
    next_s.awRdy = !next_s.awHave && !next_s.bValid;
    next_s.wRdy = !next_s.wHave && !next_s.bValid;
    next_s.arRdy = !next_s.rValid;

    // Counter: wraps at the top, cleared only by stop or pulse period
    if (s.mode == MODE_STOP) begin
      next_s.count = 16'h0000;
    end else if (countTick) begin
      if (s.mode == MODE_PULSE && s.count == s.cmp1) begin
        next_s.count = 16'h0000;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end

    // Captures take the current count; the flag set wins over a clear
    if (capMode && evHit) begin
      next_s.cmp2 = s.count;
      next_s.flag1 = 1'b1;
      next_s.irq1 = 1'b1;
    end
    if (s.mode == MODE_DUAL && secHit) begin
      next_s.cmp1 = s.count;
      next_s.flag2 = 1'b1;
      next_s.irq2 = 1'b1;
    end
    if (s.mode == MODE_CAP2REG && invHit) begin
      next_s.cmp1 = s.count;
    end

    // Registered pin: disabled output rests low
    next_s.outPin = s.outCtl[OUT_EN_BIT] && (active ^ s.outCtl[ACT_LVL_BIT]);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign awready = s.awRdy;
  assign wready = s.wRdy;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arRdy;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;
  assign timerOutputPin = s.outPin;
  assign firstExtIrq = s.irq1;
  assign secondExtIrq = s.irq2;

  // ==================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence wrPair;
    s.awHave && s.wHave && !s.bValid;
  endsequence
  sequence wrAnswer;
    bvalid && !awready && !wready;
  endsequence

  a_write_answer: assert property (wrPair |=> wrAnswer)
    else $error("write pair not answered");
  a_event_capture: assert property (capMode && evHit |=> s.cmp2 == $past(s.count) && s.flag1 && firstExtIrq)
    else $error("event capture missed");
  a_second_capture: assert property (s.mode == MODE_DUAL && secHit |=> s.cmp1 == $past(s.count) && s.flag2)
    else $error("second pin capture missed");
  a_inverse_capture: assert property (s.mode == MODE_CAP2REG && invHit |=> s.cmp1 == $past(s.count))
    else $error("opposite edge capture missed");
  a_both_no_inv: assert property (s.mode == MODE_CAP2REG && s.edgeMode[3:2] == EDGE_BOTH && !wrCmp1
    |=> $stable(s.cmp1))
    else $error("both-edge setting changed compare one");
  a_counter_wrap: assert property (s.mode != MODE_STOP && s.mode != MODE_PULSE && countTick
    && s.count == CNT_MAX |=> s.count == 16'h0000)
    else $error("counter did not wrap");
  a_pulse_shape: assert property (s.mode == MODE_PULSE && s.outCtl == 2'b01
    |=> timerOutputPin == ($past(s.count) <= $past(s.cmp2)))
    else $error("pulse output wrong");
  a_pwm_level: assert property (s.mode == MODE_PWM && s.outCtl[OUT_EN_BIT]
    |=> timerOutputPin == ($past(pwmActive) ^ $past(s.outCtl[ACT_LVL_BIT])))
    else $error("pwm output level wrong");
  a_out_disabled: assert property (!s.outCtl[OUT_EN_BIT] |=> !timerOutputPin)
    else $error("disabled output not low");
endmodule
`default_nettype wire

/* File: verification/pin_partner.sv */
// Purpose: Pin-side model: drives both capture pins, watches the output pin
// Assumes: Pins change just after a rising edge, synchronous to clock
// Notes:   All counts restart while clearCounts is high
`default_nettype none
module pin_partner (
  input wire logic clock,          // System clock
  input wire logic resetn,         // Async reset, active low
  input wire logic evLevel,        // Wanted event pin level
  input wire logic secLevel,       // Wanted second pin level
  input wire logic clearCounts,    // Restart all counts
  input wire logic timerOutputPin, // Output from the block
  input wire logic firstExtIrq,    // Event capture pulse
  input wire logic secondExtIrq,   // Second capture pulse
  output logic eventInputPin,      // Driven event pin
  output logic secondCapturePin,   // Driven second pin
  output logic [15:0] highCount,   // Cycles with output high
  output logic [15:0] riseCount,   // Output rising edges
  output logic [7:0] irq1Count,    // Event capture pulses
  output logic [7:0] irq2Count     // Second capture pulses
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastOut;
  // ==================================================
  // Registered pin drive keeps the pins synchronous, as the block expects
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      eventInputPin <= 1'b0;
      secondCapturePin <= 1'b0;
      lastOut <= 1'b0;
      highCount <= 16'h0000;
      riseCount <= 16'h0000;
      irq1Count <= 8'h00;
      irq2Count <= 8'h00;
    end else begin
      eventInputPin <= evLevel;
      secondCapturePin <= secLevel;
      lastOut <= timerOutputPin;
      if (clearCounts) begin
        highCount <= 16'h0000;
        riseCount <= 16'h0000;
        irq1Count <= 8'h00;
        irq2Count <= 8'h00;
      end else begin
        highCount <= highCount + {15'h0000, timerOutputPin};
        riseCount <= riseCount + {15'h0000, timerOutputPin & ~lastOut};
        irq1Count <= irq1Count + {7'h00, firstExtIrq};
        irq2Count <= irq2Count + {7'h00, secondExtIrq};
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/timer_pwm_ppg_pulse_capture_bench.sv */
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: AXI4-Lite master tasks, pins driven through the pin model
// Notes:   Captured counts are unknown, so order relations are checked
`default_nettype none
module timer_pwm_ppg_pulse_capture_bench;
  import timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, evLevel = 1'b0, secLevel = 1'b0, clearCounts = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000, v, w;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] resp;
  logic awready, wready, bvalid, arready, rvalid, timerOutputPin, firstExtIrq, secondExtIrq;
  logic eventInputPin, secondCapturePin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] highCount, riseCount;
  logic [7:0] irq1Count, irq2Count;
  int miscompares = 0, comparisons = 0, cycles = 0;
  logic [1:0] codes [4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, 2'h2};
  logic [7:0] hits [4] = '{8'h01, 8'h01, 8'h02, 8'h00};
  timer_capture i_dut (.clock(clock), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .eventInputPin(eventInputPin),
    .secondCapturePin(secondCapturePin), .timerOutputPin(timerOutputPin), .firstExtIrq(firstExtIrq),
    .secondExtIrq(secondExtIrq));
  pin_partner i_pins (.clock(clock), .resetn(resetn), .evLevel(evLevel), .secLevel(secLevel),
    .clearCounts(clearCounts), .timerOutputPin(timerOutputPin), .firstExtIrq(firstExtIrq),
    .secondExtIrq(secondExtIrq), .eventInputPin(eventInputPin), .secondCapturePin(secondCapturePin),
    .highCount(highCount), .riseCount(riseCount), .irq1Count(irq1Count), .irq2Count(irq2Count));
  // ==================================================
  // Clock and hang guard; four PWM windows dominate the run time
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==================================================
  // Reporting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==================================================
  // Bus master: payload held until each channel's own handshake edge
  task automatic axWrite(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axRead(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    axWrite(a, d, resp);
    check("bresp", 32'(resp), 32'(RESP_OKAY));
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    axRead(a, d, resp);
    check("rresp", 32'(resp), 32'(RESP_OKAY));
  endtask
  // Counts the output pin over exactly n cycles
  task automatic measure(input int n);
    @(posedge clock);
    clearCounts <= 1'b1;
    @(posedge clock);
    clearCounts <= 1'b0;
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // Event pin pulse of a given width, then a long low stretch
  task automatic pulseEv(input int width);
    @(posedge clock);
    clearCounts <= 1'b1;
    evLevel <= 1'b1;
    @(posedge clock);
    clearCounts <= 1'b0;
    repeat (width - 1) @(posedge clock);
    evLevel <= 1'b0;
    repeat (60) @(posedge clock);
  endtask
  task automatic capMode(input logic [2:0] mode, input logic [31:0] edges);
    wr(OFF_MODE, 32'(MODE_STOP));
    wr(OFF_EDGE, edges);
    wr(OFF_MODE, 32'(mode));
  endtask
  // ==================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rd(OFF_CMP1, v);
    check("cmp1 reset", v, 32'(RESET_CMP));
    axRead(6'h3C, v, resp);
    check("unmapped rresp", 32'(resp), 32'(RESP_SLVERR));
    check("unmapped rdata", v, 32'h00000000);
    axWrite(6'h3C, 32'hFFFFFFFF, resp);
    check("unmapped bresp", 32'(resp), 32'(RESP_SLVERR));
    $display("test reset done");
    wr(OFF_CLKSEL, 32'(CSEL_DIV1) << CLK_SEL_LO);
    wr(OFF_SAMPLE, 32'(SMP_DIV1));
    for (int i = 0; i < 4; i++) begin
      capMode(MODE_CAP1, 32'(codes[i]) << EV_EDGE_LO);
      pulseEv(10);
      check("edge irq count", 32'(irq1Count), 32'(hits[i]));
    end
    rd(OFF_FLAGS, v);
    check("flag1 set", v & 32'h1, 32'h1);
    wr(OFF_FLAGS, 32'h1);
    rd(OFF_FLAGS, v);
    check("flag1 cleared", v, 32'h0);
    capMode(MODE_CAP1, 32'(EDGE_RISE) << EV_EDGE_LO);
    pulseEv(10);
    rd(OFF_CMP2, v);
    rd(OFF_COUNT, w);
    check("capture below count", 32'(v[15:0] < w[15:0] && v[15:0] != 16'h0000), 32'h1);
    pulseEv(1);
    check("glitch ignored", 32'(irq1Count), 32'h0);
    wr(OFF_SAMPLE, 32'(SMP_DIV16));
    pulseEv(12);
    check("short pulse ignored", 32'(irq1Count), 32'h0);
    pulseEv(40);
    check("long pulse caught", 32'(irq1Count), 32'h1);
    wr(OFF_SAMPLE, 32'(SMP_DIV1));
    $display("test capture done");
    wr(OFF_CMP1, 32'h0);
    capMode(MODE_DUAL, (32'(EDGE_RISE) << SEC_EDGE_LO) | (32'(EDGE_RISE) << EV_EDGE_LO));
    measure(2);
    @(posedge clock);
    secLevel <= 1'b1;
    repeat (10) @(posedge clock);
    secLevel <= 1'b0;
    repeat (10) @(posedge clock);
    check("second irq", 32'(irq2Count), 32'h1);
    rd(OFF_FLAGS, v);
    check("flag2 set", v & 32'h2, 32'h2);
    rd(OFF_CMP1, v);
    check("cmp1 captured", 32'(v[15:0] != 16'h0000), 32'h1);
    capMode(MODE_CAP2REG, 32'(EDGE_RISE) << EV_EDGE_LO);
    pulseEv(10);
    rd(OFF_CMP2, v);
    rd(OFF_CMP1, w);
    check("fall after rise", 32'(w[15:0] > v[15:0]), 32'h1);
    wr(OFF_MODE, 32'(MODE_STOP));
    wr(OFF_CMP1, 32'h0);
    capMode(MODE_CAP2REG, 32'(EDGE_BOTH) << EV_EDGE_LO);
    pulseEv(10);
    rd(OFF_CMP1, w);
    check("both edges no cmp1", w, 32'h0);
    $display("test dual done");
    wr(OFF_MODE, 32'(MODE_STOP));
    wr(OFF_CMP1, 32'd9);
    wr(OFF_CMP2, 32'd3);
    wr(OFF_OUTCTL, 32'h1);
    wr(OFF_MODE, 32'(MODE_PULSE));
    measure(100);
    check("pulse high", 32'(highCount), 32'd40);
    check("pulse period", 32'(riseCount), 32'd10);
    wr(OFF_CLKSEL, 32'(CSEL_DIV2) << CLK_SEL_LO);
    measure(200);
    check("div2 period", 32'(riseCount), 32'd10);
    check("div2 high", 32'(highCount), 32'd80);
    wr(OFF_CLKSEL, 32'(CSEL_DIV4) << CLK_SEL_LO);
    measure(400);
    check("div4 high", 32'(highCount), 32'd160);
    $display("test pulse done");
    wr(OFF_CLKSEL, 32'(CSEL_DIV1) << CLK_SEL_LO);
    wr(OFF_MODE, 32'(MODE_PWM));
    wr(OFF_CMP1, 32'h4104);
    measure(16384);
    check("pwm active high", 32'(highCount), 32'd4161);
    wr(OFF_OUTCTL, 32'h3);
    measure(16384);
    check("pwm active low", 32'(highCount), 32'd12223);
    wr(OFF_OUTCTL, 32'h0);
    measure(16384);
    check("pwm disabled", 32'(highCount), 32'd0);
    // Fourth window carries the free counter through its top value
    wr(OFF_OUTCTL, 32'h1);
    measure(16384);
    check("pwm across wrap", 32'(highCount), 32'd4161);
    rd(OFF_COUNT, w);
    check("counter wrapped", 32'(w[15:0] < 16'h4000), 32'h1);
    $display("test pwm done");
    give_verdict();
  end
endmodule
`default_nettype wire
